//--- hdl/asc_pkg.sv
// Package: shared constants, carriers and helpers of the serial unit.
// Assumes one 100 MHz clock and a plain register port.
package asc_pkg;
    // ------------------------------------------------------------
    // Register map and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ASC_OFS_CTL1 = 8'h10;
    localparam logic [7:0] ASC_OFS_CTL2 = 8'h14;
    localparam logic [7:0] ASC_OFS_STAT = 8'h18;
    localparam logic [7:0] ASC_OFS_DATA = 8'h1c;
    localparam logic [7:0] ASC_CTL_RST  = 8'h00;
    // Status bit positions
    localparam int ASC_ST_TXE  = 0;
    localparam int ASC_ST_TXD  = 1;
    localparam int ASC_ST_RXF  = 2;
    localparam int ASC_ST_IDLE = 3;
    localparam int ASC_ST_PERR = 4;
    // ------------------------------------------------------------
    // Timing and frame lengths
    // ------------------------------------------------------------
    localparam int         ASC_BIT_CLKS  = 16;
    localparam logic [3:0] ASC_LEN_SHORT = 4'ha;
    localparam logic [3:0] ASC_LEN_LONG  = 4'hb;

    typedef struct packed {
        logic loopback_sel;
        logic uart_on;
        logic tx_polarity_flip;
        logic char_width_sel;
        logic wake_sel;
        logic idle_count_origin;
        logic parity_on;
        logic parity_odd_sel;
    } asc_ctl1_t;

    typedef struct packed {
        logic tx_empty_irq_en;
        logic tx_done_irq_en;
        logic rx_full_irq_en;
        logic idle_irq_en;
        logic tx_on;
        logic rx_on;
        logic rx_standby;
        logic break_send;
    } asc_ctl2_t;

    typedef struct packed {
        logic long_fmt;
        logic parity_on;
        logic parity_odd;
    } asc_fmt_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } asc_bus_t;

    // Frame length in bits
    function automatic logic [3:0] asc_len(input logic long_fmt);
        return long_fmt ? ASC_LEN_LONG : ASC_LEN_SHORT;
    endfunction

    // Parity over the bits below the most significant position
    function automatic logic asc_par(input logic [8:0] d, input asc_fmt_t f);
        return (f.long_fmt ? ^d[7:0] : ^d[6:0]) ^ f.parity_odd;
    endfunction
endpackage

//--- hdl/asc_tx.sv
// Transmit shifter: preamble, break and data frames, LSB first.
// Assumes en low holds it at rest and line is the raw level.
`timescale 1ns/1ps
`default_nettype none
module asc_tx import asc_pkg::*; #(
    parameter int BIT_CLKS = ASC_BIT_CLKS
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // Control
    input  wire logic       en,
    input  wire logic       tx_on,
    input  wire logic       brk,
    input  wire asc_fmt_t   fmt,
    input  wire logic       hold_valid,
    input  wire logic [8:0] hold_data,
    // Results
    output logic            line,
    output logic            take,
    output logic            done
);
    localparam int TW = $clog2(BIT_CLKS);
    typedef struct packed {
        logic [10:0]   sh;
        logic [3:0]    cnt;
        logic [TW-1:0] tmr;
        logic busy, pre_pend, brk_pend, tail, tx_on_d, brk_d, line, take;
    } asc_txs_t;
    asc_txs_t s, n;
    logic [8:0] d;
    logic       free;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.take = 1'b0;
        n.tx_on_d = tx_on;
        n.brk_d = brk;
        d = hold_data;
        if (tx_on && !s.tx_on_d) begin
            n.pre_pend = 1'b1;
        end
        // One break queued per rising edge of the break control
        if (brk && !s.brk_d) begin
            n.brk_pend = 1'b1;
        end
        free = !s.busy;
        if (s.busy) begin
            if (s.tmr == '0) begin
                n.tmr = TW'(BIT_CLKS - 1);
                n.sh  = {1'b1, s.sh[10:1]};
                n.cnt = s.cnt - 4'h1;
                free  = (s.cnt == 4'h1);
                n.busy = !free;
            end else begin
                n.tmr = s.tmr - 1'b1;
            end
        end
        // Frames start only while enabled; otherwise line stays idle
        if (free && tx_on) begin
            n.tmr = TW'(BIT_CLKS - 1);
            n.cnt = asc_len(fmt.long_fmt);
            // Break still held after a break frame: next break, no ones
            if (n.brk_pend || (s.tail && brk)) begin
                n.sh = '0;
                n.brk_pend = 1'b0;
                n.tail = 1'b1;
                n.pre_pend = 1'b0;
                n.busy = 1'b1;
            end else if (s.tail) begin
                n.sh = '1;
                n.cnt = 4'h1;
                n.tail = 1'b0;
                n.busy = 1'b1;
            end else if (n.pre_pend) begin
                n.sh = '1;
                n.pre_pend = 1'b0;
                n.busy = 1'b1;
            end else if (hold_valid) begin
                if (fmt.parity_on) begin
                    if (fmt.long_fmt) d[8] = asc_par(hold_data, fmt);
                    else d[7] = asc_par(hold_data, fmt);
                end
                n.sh = fmt.long_fmt ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
                n.take = 1'b1;
                n.busy = 1'b1;
            end
        end
        if (!en) begin
            n = '0;
        end
        n.line = n.busy ? n.sh[0] : 1'b1;
    end

    // State register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.line <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign line = s.line;
    assign take = s.take;
    assign done = !s.busy && !s.pre_pend && !s.brk_pend && !s.tail;

    a_tx_rest_high: assert property (@(posedge clk_sys) disable iff (!rstn)
        !s.busy |-> s.line) else $error("tx line low while idle");
    a_tx_take_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
        s.take |-> s.busy && !s.line) else $error("take without start bit");
endmodule // asc_tx
`default_nettype wire

//--- hdl/asc_rx.sv
// Receive sampler: mid-bit sampling, frame extraction and idle count.
// Assumes line is already synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module asc_rx import asc_pkg::*; #(
    parameter int BIT_CLKS = ASC_BIT_CLKS
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // Control
    input  wire logic       en,
    input  wire logic       line,
    input  wire asc_fmt_t   fmt,
    input  wire logic       from_stop,
    // Results
    output logic            done,
    output logic [8:0]      data,
    output logic            perr,
    output logic            idle
);
    localparam int TW = $clog2(BIT_CLKS);
    typedef struct packed {
        logic [9:0]    sh;
        logic [8:0]    data;
        logic [3:0]    cnt, ones;
        logic [TW-1:0] tmr;
        logic busy, done, perr, idle;
    } asc_rxs_t;
    asc_rxs_t s, n;
    logic [3:0] len;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.done = 1'b0;
        n.idle = 1'b0;
        len = asc_len(fmt.long_fmt);
        if (!s.busy) begin
            if (!line) begin
                n.busy = 1'b1;
                n.cnt  = '0;
                n.ones = '0;
                n.tmr  = TW'(BIT_CLKS / 2);
            end else if (s.tmr == '0) begin
                n.tmr = TW'(BIT_CLKS - 1);
                if (s.ones != len) begin
                    n.ones = s.ones + 4'h1;
                    n.idle = (s.ones + 4'h1 == len);
                end
            end else begin
                n.tmr = s.tmr - 1'b1;
            end
        end else if (s.tmr == '0) begin
            n.tmr = TW'(BIT_CLKS - 1);
            n.cnt = s.cnt + 4'h1;
            if (s.cnt == '0) begin
                n.busy = !line;
            end else begin
                n.sh = {line, s.sh[9:1]};
                if (!from_stop) begin
                    n.ones = line ? s.ones + 4'h1 : 4'h0;
                end
                if (s.cnt == len - 4'h1) begin
                    n.busy = 1'b0;
                    n.done = 1'b1;
                    n.data = fmt.long_fmt ? n.sh[8:0] : {1'b0, n.sh[8:1]};
                    n.perr = fmt.parity_on && (asc_par(n.data, fmt) !=
                             (fmt.long_fmt ? n.data[8] : n.data[7]));
                end
            end
        end else begin
            n.tmr = s.tmr - 1'b1;
        end
        if (!en) begin
            n = '0;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) s <= '0;
        else s <= n;
    end

    assign done = s.done;
    assign data = s.data;
    assign perr = s.perr;
    assign idle = s.idle;
endmodule // asc_rx
`default_nettype wire

//--- hdl/asc_top.sv
// Serial unit control: registers, pin takeover, loopback, wakeup.
// Assumes a plain register port with read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module asc_top import asc_pkg::*; #(
    parameter int BIT_CLKS = ASC_BIT_CLKS
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // Register port
    input  wire asc_bus_t    bus_req,
    output logic [15:0]      rd_data,
    // Transmit pin and its port fallback
    input  wire logic        pin0_in,
    output logic             pin0_out,
    output logic             pin0_oe,
    input  wire logic        port_out_zero,
    input  wire logic        port_dir_bit_zero,
    // Receive pin and its port fallback
    input  wire logic        pin1_in,
    output logic             pin1_out,
    output logic             pin1_oe,
    input  wire logic        port_out_one,
    input  wire logic        port_dir_bit_one,
    // Interrupt requests
    output logic             tx_irq,
    output logic             rx_irq
);
    typedef struct packed {
        asc_ctl1_t   c1;
        asc_ctl2_t   c2;
        logic        tx_empty, rx_full, idle, perr, armed;
        logic [8:0]  hold, rxd;
        logic [15:0] rdata;
    } asc_st_t;
    asc_st_t s, n;

    logic       tx_line, tx_take, tx_idle, tx_done_w;
    logic       rx_line, rx_done, rx_perr, rx_idle, rx_msb;
    logic [8:0] rx_data;
    asc_fmt_t   fmt;
    logic [4:0] stat;
    logic       ctl2_wr;

    // ------------------------------------------------------------
    // Format and pin routing
    // ------------------------------------------------------------
    assign fmt = '{long_fmt: s.c1.char_width_sel, parity_on: s.c1.parity_on,
                   parity_odd: s.c1.parity_odd_sel};
    // Pin 0 serves the transmitter whenever the unit is on
    assign pin0_oe  = s.c1.uart_on ? 1'b1 : port_dir_bit_zero;
    assign pin0_out = s.c1.uart_on ? tx_line ^ s.c1.tx_polarity_flip
                                   : port_out_zero;
    // Pin 1 serves the receiver whenever the unit is on and loopback is not selected
    assign pin1_oe  = s.c1.uart_on ? 1'b0 : port_dir_bit_one;
    assign pin1_out = port_out_one;
    // Loopback detaches the receive pin
    assign rx_line  = s.c1.loopback_sel ? tx_line : pin1_in;
    assign rx_msb   = s.c1.char_width_sel ? rx_data[8] : rx_data[7];
    // Done is forced while the unit is off
    assign tx_done_w = !s.c1.uart_on || (s.tx_empty && tx_idle);
    assign stat = {s.perr, s.idle, s.rx_full, tx_done_w, s.tx_empty};
    assign ctl2_wr = bus_req.wr && bus_req.addr == ASC_OFS_CTL2;

    // ------------------------------------------------------------
    // Transmitter and receiver
    // ------------------------------------------------------------
    asc_tx #(.BIT_CLKS(BIT_CLKS)) u_tx (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .en         (s.c1.uart_on),
        .tx_on      (s.c2.tx_on),
        .brk        (s.c2.break_send),
        .fmt        (fmt),
        .hold_valid (!s.tx_empty),
        .hold_data  (s.hold),
        .line       (tx_line),
        .take       (tx_take),
        .done       (tx_idle)
    );

    asc_rx #(.BIT_CLKS(BIT_CLKS)) u_rx (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .en         (s.c1.uart_on && s.c2.rx_on),
        .line       (rx_line),
        .fmt        (fmt),
        .from_stop  (s.c1.idle_count_origin),
        .done       (rx_done),
        .data       (rx_data),
        .perr       (rx_perr),
        .idle       (rx_idle)
    );

    // ------------------------------------------------------------
    // Register file and flags
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.rdata = '0;
        // Software writes
        if (bus_req.wr) begin
            case (bus_req.addr)
                ASC_OFS_CTL1: n.c1 = bus_req.wdata[7:0];
                ASC_OFS_CTL2: n.c2 = bus_req.wdata[7:0];
                ASC_OFS_DATA: begin
                    n.hold = bus_req.wdata[8:0];
                    n.tx_empty = 1'b0;
                end
                default: ;
            endcase
        end
        // Software reads, data read clears receive flags
        if (bus_req.rd) begin
            case (bus_req.addr)
                ASC_OFS_CTL1: n.rdata = {8'h00, s.c1};
                ASC_OFS_CTL2: n.rdata = {8'h00, s.c2};
                ASC_OFS_STAT: n.rdata = {11'h000, stat};
                ASC_OFS_DATA: begin
                    n.rdata = {7'h00, s.rxd};
                    n.rx_full = 1'b0;
                    n.idle = 1'b0;
                    n.perr = 1'b0;
                end
                default: n.rdata = '0;
            endcase
        end
        // Hardware sets win over software clears
        if (tx_take || !s.c1.uart_on) begin
            n.tx_empty = 1'b1;
        end
        // Receive flags are set only on receiver events
        if (rx_done) begin
            if (!s.c2.rx_standby) begin
                n.rx_full = 1'b1;
                n.rxd = rx_data;
                n.perr = rx_perr;
                n.armed = 1'b1;
            end else if (s.c1.wake_sel && rx_msb) begin
                n.rx_full = 1'b1;
                n.rxd = rx_data;
                n.armed = 1'b1;
                if (!ctl2_wr) n.c2.rx_standby = 1'b0;
            end
        end
        if (rx_idle) begin
            if (s.c2.rx_standby) begin
                if (!s.c1.wake_sel && !ctl2_wr) n.c2.rx_standby = 1'b0;
            end else if (s.armed) begin
                n.idle = 1'b1;
                n.armed = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.c1 <= ASC_CTL_RST;
            s.c2 <= ASC_CTL_RST;
            s.tx_empty <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rd_data = s.rdata;
    // Gated interrupt requests
    assign tx_irq = s.c1.uart_on && ((s.c2.tx_empty_irq_en && s.tx_empty) ||
                    (s.c2.tx_done_irq_en && tx_done_w));
    assign rx_irq = !s.c2.rx_standby && ((s.c2.rx_full_irq_en && s.rx_full) ||
                    (s.c2.idle_irq_en && s.idle));

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_ctl_reset_zero: assert property ($rose(rstn) |-> s.c1 == 8'h00 && s.c2 == 8'h00)
        else $error("control not cleared by reset");
    a_tx_pin_owned: assert property (s.c1.uart_on |-> pin0_oe && pin0_out ==
        (tx_line ^ s.c1.tx_polarity_flip)) else $error("tx pin not owned");
    a_rx_pin_input: assert property (s.c1.uart_on |-> !pin1_oe)
        else $error("rx pin driven while on");
    a_loop_route: assert property (s.c1.loopback_sel |-> rx_line == tx_line)
        else $error("loopback not routed");
    a_off_tx_forced: assert property (!s.c1.uart_on |->
        tx_done_w && !tx_irq ##1 s.tx_empty) else $error("tx flags not forced when off");
    a_flip_all: assert property (s.c1.uart_on && s.c1.tx_polarity_flip && tx_idle
        |-> !pin0_out) else $error("idle level not inverted");
    a_standby_quiet: assert property (s.c2.rx_standby |-> !rx_irq)
        else $error("rx irq during standby");
    a_idle_wake: assert property (s.c2.rx_standby && !s.c1.wake_sel && rx_idle
        && !ctl2_wr |=> !s.c2.rx_standby && s.idle == $past(s.idle))
        else $error("idle wake misbehaved");
    a_addr_wake: assert property (s.c2.rx_standby && s.c1.wake_sel && rx_done
        && rx_msb && !ctl2_wr |=> !s.c2.rx_standby && s.rx_full)
        else $error("address wake misbehaved");
    a_rd_slot: assert property (bus_req.rd && bus_req.addr == ASC_OFS_CTL2
        |=> rd_data == {8'h00, $past(s.c2)} ##1 rd_data == 16'h0000 || $past(bus_req.rd))
        else $error("read data slot wrong");

    c_loop_char: cover property (s.c1.loopback_sel && rx_done && !rx_perr);
    c_break_held: cover property (s.c2.break_send && tx_take == 1'b0 && !tx_line [*8]);
    c_addr_wake: cover property (s.c2.rx_standby ##1 !s.c2.rx_standby && s.rx_full);
    c_idle_flag: cover property ($rose(s.idle));
endmodule // asc_top
`default_nettype wire

//--- testbench/asc_far.sv
// Far-side serial device: sends one frame on the receive line.
// Assumes go is a one-cycle pulse and nbits is 10 or 11.
`timescale 1ns/1ps
`default_nettype none
module asc_far #(
    parameter int BIT_CLKS = 4
) (
    // Clock
    input  wire logic       clk_sys,
    // Frame request
    input  wire logic       go,
    input  wire logic [3:0] nbits,
    input  wire logic [8:0] chr,
    // Line
    output logic            line
);
    logic [11:0] sh_r = '1;
    int          cnt_r = 0;
    // Line idles high between frames
    assign line = sh_r[0];
    // Start bit, LSB first, one stop bit
    always_ff @(posedge clk_sys) begin
        if (go) begin
            sh_r           <= {2'b11, chr, 1'b0};
            sh_r[nbits - 1] <= 1'b1;
            cnt_r          <= int'(nbits) * BIT_CLKS;
        end else if (cnt_r != 0) begin
            cnt_r <= cnt_r - 1;
            if (cnt_r % BIT_CLKS == 1) begin
                sh_r <= {1'b1, sh_r[11:1]};
            end
        end
    end
endmodule // asc_far
`default_nettype wire

//--- testbench/tb_asc_top.sv
// Testbench of the serial unit control block.
// Assumes asc_top with a small bit time and the model asc_far.
`timescale 1ns/1ps
`default_nettype none
module tb_asc_top import asc_pkg::*;;
    localparam int BC = 4;
    logic        clk_sys = 1'b0;
    logic        rstn    = 1'b0;
    asc_bus_t    bus     = '0;
    logic [15:0] rd_data;
    logic        pin0_out, pin0_oe, pin1_out, pin1_oe, tx_irq, rx_irq, far_line;
    logic        d0 = 1'b0, d1 = 1'b1, p0 = 1'b0, p1 = 1'b0, go = 1'b0;
    logic [3:0]  nb = 4'ha;
    logic [8:0]  chr = 9'h000;
    int          fail_count = 0;
    int          compares = 0;
    // Clock
    always #5 clk_sys = ~clk_sys;
    asc_top #(.BIT_CLKS(BC)) dut (.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus),
        .rd_data(rd_data), .pin0_in(pin0_out), .pin0_out(pin0_out), .pin0_oe(pin0_oe),
        .port_out_zero(p0), .port_dir_bit_zero(d0), .pin1_in(far_line),
        .pin1_out(pin1_out), .pin1_oe(pin1_oe), .port_out_one(p1),
        .port_dir_bit_one(d1), .tx_irq(tx_irq), .rx_irq(rx_irq));
    asc_far #(.BIT_CLKS(BC)) far (.clk_sys(clk_sys), .go(go), .nbits(nb), .chr(chr),
        .line(far_line));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e,
                       input string nm);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1;
        chk(nm, e, rd_data & m);
    endtask
    task automatic send(input logic [3:0] n, input logic [8:0] c, input int w);
        @(posedge clk_sys);
        go  <= 1'b1;
        nb  <= n;
        chr <= c;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (w) @(posedge clk_sys);
    endtask
    // Waits for a start bit, samples each bit at mid-bit
    task automatic fr(input int n, input logic inv, input logic [10:0] e, input string nm,
                      output int k);
        logic [10:0] got;
        got = '0;
        k = 0;
        while (pin0_out !== inv && k < 400) begin
            @(negedge clk_sys);
            k++;
        end
        @(negedge clk_sys);
        for (int i = 0; i < n; i++) begin
            got[i] = pin0_out ^ inv;
            repeat (BC) @(negedge clk_sys);
        end
        chk(nm, 16'(e), 16'(got));
        repeat (2 * BC) @(negedge clk_sys);
    endtask
    task automatic end_sim;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_rst;
        rdc(ASC_OFS_CTL1, 16'hffff, 16'h0000, "ctl1");
        rdc(ASC_OFS_CTL2, 16'hffff, 16'h0000, "ctl2");
        rdc(ASC_OFS_STAT, 16'h0003, 16'h0003, "txflags");
        rdc(8'h40, 16'hffff, 16'h0000, "unmapped");
        chk("pin0_oe", 16'(d0), 16'(pin0_oe));
        chk("pin0_out", 16'(p0), 16'(pin0_out));
        chk("pin1_oe", 16'(d1), 16'(pin1_oe));
        chk("pin1_out", 16'(p1), 16'(pin1_out));
        $display("reset test done");
    endtask
    task automatic t_tx;
        int k;
        wr(ASC_OFS_CTL1, 16'h0040);
        chk("pin0_oe", 16'h0001, 16'(pin0_oe));
        chk("pin1_oe", 16'h0000, 16'(pin1_oe));
        wr(ASC_OFS_CTL2, 16'h0088);
        wr(ASC_OFS_DATA, 16'h00a5);
        fr(10, 1'b0, 11'h34a, "frame", k);
        chk("preamble", 16'h0001, 16'(k >= 34 && k <= 40));
        chk("tx_irq", 16'h0001, 16'(tx_irq));
        wr(ASC_OFS_CTL1, 16'h0000);
        chk("tx_irq off", 16'h0000, 16'(tx_irq));
        rdc(ASC_OFS_STAT, 16'h0003, 16'h0003, "txflags");
        wr(ASC_OFS_CTL1, 16'h0043);
        wr(ASC_OFS_DATA, 16'h0003);
        fr(10, 1'b0, 11'h306, "odd short", k);
        wr(ASC_OFS_CTL1, 16'h0052);
        wr(ASC_OFS_DATA, 16'h00ff);
        fr(11, 1'b0, 11'h5fe, "even long", k);
        wr(ASC_OFS_CTL1, 16'h0060);
        chk("idle inv", 16'h0000, 16'(pin0_out));
        wr(ASC_OFS_DATA, 16'h005a);
        fr(10, 1'b1, 11'h2b4, "inv frame", k);
        wr(ASC_OFS_CTL1, 16'h0040);
        wr(ASC_OFS_CTL2, 16'h0009);
        wr(ASC_OFS_CTL2, 16'h0008);
        fr(11, 1'b0, 11'h400, "break", k);
        wr(ASC_OFS_CTL2, 16'h0009);
        fr(11, 1'b0, 11'h000, "held break", k);
        wr(ASC_OFS_CTL2, 16'h0008);
        $display("transmit test done");
    endtask
    task automatic t_rx;
        wr(ASC_OFS_CTL2, 16'h0004);
        send(4'ha, 9'h03c, 48);
        rdc(ASC_OFS_STAT, 16'h0004, 16'h0004, "rx_full");
        wr(ASC_OFS_CTL2, 16'h0000);
        rdc(ASC_OFS_STAT, 16'h0004, 16'h0004, "rx_full kept");
        rdc(ASC_OFS_DATA, 16'h00ff, 16'h003c, "rx data");
        wr(ASC_OFS_CTL1, 16'h0058);
        wr(ASC_OFS_CTL2, 16'h0026);
        send(4'hb, 9'h0ff, 52);
        chk("rx_irq standby", 16'h0000, 16'(rx_irq));
        rdc(ASC_OFS_CTL2, 16'hffff, 16'h0026, "no wake");
        send(4'hb, 9'h1aa, 52);
        rdc(ASC_OFS_CTL2, 16'hffff, 16'h0024, "addr wake");
        rdc(ASC_OFS_STAT, 16'h0004, 16'h0004, "wake full");
        chk("rx_irq", 16'h0001, 16'(rx_irq));
        rdc(ASC_OFS_DATA, 16'h01ff, 16'h01aa, "wake data");
        wr(ASC_OFS_CTL1, 16'h0040);
        wr(ASC_OFS_CTL2, 16'h0006);
        repeat (60) @(posedge clk_sys);
        rdc(ASC_OFS_CTL2, 16'hffff, 16'h0004, "idle wake");
        rdc(ASC_OFS_STAT, 16'h000c, 16'h0000, "idle flags");
        $display("receive test done");
    endtask
    task automatic t_lp;
        wr(ASC_OFS_CTL1, 16'h00c0);
        wr(ASC_OFS_CTL2, 16'h000c);
        wr(ASC_OFS_DATA, 16'h0066);
        send(4'ha, 9'h011, 100);
        rdc(ASC_OFS_DATA, 16'h00ff, 16'h0066, "loop data");
        $display("loopback test done");
    endtask
    task automatic t_idl;
        wr(ASC_OFS_CTL1, 16'h0047);
        wr(ASC_OFS_CTL2, 16'h0014);
        repeat (40) @(posedge clk_sys);
        rdc(ASC_OFS_DATA, 16'h00ff, 16'h0066, "data kept");
        send(4'ha, 9'h003, 77);
        rdc(ASC_OFS_STAT, 16'h001c, 16'h0014, "idle after stop");
        chk("rx_irq idle off", 16'h0000, 16'(rx_irq));
        repeat (8) @(posedge clk_sys);
        rdc(ASC_OFS_STAT, 16'h001c, 16'h001c, "idle flag");
        chk("rx_irq idle", 16'h0001, 16'(rx_irq));
        rdc(ASC_OFS_DATA, 16'h00ff, 16'h0003, "parity data");
        $display("idle and parity test done");
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        t_rst();
        t_tx();
        t_rx();
        t_lp();
        t_idl();
        end_sim();
    end
    // Watchdog
    initial begin
        #300000;
        fail_count++;
        end_sim();
    end
endmodule // tb_asc_top
`default_nettype wire
